// file: hw/cpi_pins.sv
// Pin interface: cycle clocks, memory and I/O bus strobes, interrupts.
`timescale 1ns/1ns
`default_nettype none
module cpi_pins (
    // Clock and reset; CLK is the double-rate input clock.
    input wire logic CLK,
    input wire logic RSTN,
    // Board control pins.
    input wire logic RESET_IN,
    input wire logic WAIT_IN,
    // Interrupt pins.
    input wire logic [cpi_pkg::LEVEL_IRQS-1:0] EXT_IRQ_LEVEL_INPUTS,
    input wire logic [cpi_pkg::TIMER_IRQS-1:0] EXT_IRQ_TIMER_INPUTS,
    input wire logic NMI_IN,
    input wire logic IRQ_INHIBIT_IN,
    // Clock outputs.
    output logic CYCLE_CLOCK_OUT,
    output logic FREE_TIMING_CLOCK_OUT,
    // Memory bus pins.
    output logic FETCH_OUT,
    output logic BOOT_SPACE_OUT,
    output logic MEM_READ_WRITE_N,
    output logic UPPER_BYTE_SELECT,
    output logic LOWER_BYTE_SELECT,
    output logic [cpi_pkg::MEM_ADDR_W-1:0] MEM_WORD_ADDR_BUS,
    input wire logic [cpi_pkg::DATA_W-1:0] MEM_DATA_BUS_I,
    output logic [cpi_pkg::DATA_W-1:0] MEM_DATA_BUS_O,
    output logic MEM_DATA_BUS_OE,
    // Peripheral I/O bus pins.
    output logic IO_CYCLE_N,
    output logic IO_READ_WRITE_N,
    output logic [cpi_pkg::IO_ADDR_W-1:0] IO_ADDR_BUS,
    input wire logic [cpi_pkg::DATA_W-1:0] IO_DATA_BUS_I,
    output logic [cpi_pkg::DATA_W-1:0] IO_DATA_BUS_O,
    output logic IO_DATA_BUS_OE,
    output logic IRQ_ACKNOWLEDGE_OUT,
    // Core request side.
    input wire cpi_pkg::cpi_kind_t REQ_KIND,
    input wire logic [cpi_pkg::MEM_ADDR_W-1:0] REQ_MEM_ADDR,
    input wire logic [1:0] REQ_BYTE_EN,
    input wire logic [cpi_pkg::IO_ADDR_W-1:0] REQ_IO_ADDR,
    input wire logic [cpi_pkg::DATA_W-1:0] REQ_WDATA,
    input wire logic [cpi_pkg::MEM_ADDR_W-1:0] REQ_FETCH_ADDR,
    input wire logic BOOT_SELECT,
    output logic REQ_TAKEN,
    // Core answer side.
    output logic RSP_VALID,
    output logic [cpi_pkg::DATA_W-1:0] RSP_DATA,
    // Core interrupt side.
    output logic [cpi_pkg::IRQS-1:0] IRQ_LEVELS,
    output logic IRQ_PENDING,
    output logic [cpi_pkg::TIMER_IRQS-1:0] TIMER_TICK,
    output logic NMI_PENDING,
    input wire logic NMI_CLEAR,
    output logic CORE_RESET_OUT
);
    import cpi_pkg::*;

    logic reset_s;
    logic wait_s;
    logic nmi_s;
    logic inh_s;
    logic [LEVEL_IRQS-1:0] lvl_s;
    logic [TIMER_IRQS-1:0] tmr_s;
    logic [DATA_W-1:0] md_s;
    logic [DATA_W-1:0] gd_s;
    logic [2:0] rst_cnt_q;
    logic pin_rst_q;
    logic rst;
    logic cyc_edge;
    logic data_cycle_q;
    logic nmi_prev_q;
    logic [TIMER_IRQS-1:0] tmr_prev_q;
    cpi_kind_t kind_d;
    cpi_kind_t kind_q;
    logic rsp_due_q;
    logic rsp_io_q;

    // Returns true for kinds whose data the core wants back.
    function automatic logic is_read(input cpi_kind_t k);
        is_read = (k == CPI_FETCH) || (k == CPI_MEM_RD) || (k == CPI_IO_RD);
    endfunction : is_read

    // Returns true for kinds that use the memory bus for data.
    function automatic logic is_mem_data(input cpi_kind_t k);
        is_mem_data = (k == CPI_MEM_RD) || (k == CPI_MEM_WR);
    endfunction : is_mem_data

    // Every pin input but RSTN is synchronised before any logic reads it.
    cpi_sync #(.W(4)) u_sync_ctl (
        .clk(CLK),
        .rst_n(RSTN),
        .d({RESET_IN, WAIT_IN, NMI_IN, IRQ_INHIBIT_IN}),
        .q({reset_s, wait_s, nmi_s, inh_s})
    );
    cpi_sync #(.W(IRQS)) u_sync_irq (
        .clk(CLK),
        .rst_n(RSTN),
        .d({EXT_IRQ_TIMER_INPUTS, EXT_IRQ_LEVEL_INPUTS}),
        .q({tmr_s, lvl_s})
    );
    cpi_sync #(.W(2 * DATA_W)) u_sync_data (
        .clk(CLK),
        .rst_n(RSTN),
        .d({MEM_DATA_BUS_I, IO_DATA_BUS_I}),
        .q({md_s, gd_s})
    );

    // The reset pin must be seen high on four straight clocks; a shorter
    // glitch is ignored. Reset then lasts as long as the pin stays high.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            rst_cnt_q <= 3'h0;
            pin_rst_q <= 1'b0;
        end
        else if (!reset_s)
        begin
            rst_cnt_q <= 3'h0;
            pin_rst_q <= 1'b0;
        end
        else if (rst_cnt_q + 3'h1 >= RESET_HOLD_CNT)
        begin
            rst_cnt_q <= RESET_HOLD_CNT;
            pin_rst_q <= 1'b1;
        end
        else
        begin
            rst_cnt_q <= rst_cnt_q + 3'h1;
        end
    end

    assign rst = !RSTN || pin_rst_q;

    // Core reset output mirrors the combined reset.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            CORE_RESET_OUT <= 1'b1;
        else
            CORE_RESET_OUT <= pin_rst_q;
    end

    cpi_clkgen u_clkgen (
        .clk(CLK),
        .rst(rst),
        .hold(wait_s),
        .edge_go(cyc_edge),
        .pclk_q(CYCLE_CLOCK_OUT),
        .free_timing_clock_out_q(FREE_TIMING_CLOCK_OUT)
    );

    // After a data access the next cycle is always the fetch, whatever
    // the core asks; the core keeps its request until it is taken.
    always_comb
    begin
        if (data_cycle_q)
            kind_d = CPI_FETCH;
        else
            kind_d = REQ_KIND;
    end

    // Cycle bookkeeping, advanced only where a cycle opens.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            kind_q <= CPI_IDLE;
            data_cycle_q <= 1'b0;
            REQ_TAKEN <= 1'b0;
        end
        else
        begin
            REQ_TAKEN <= cyc_edge && !data_cycle_q;
            if (cyc_edge)
            begin
                kind_q <= kind_d;
                data_cycle_q <= is_mem_data(kind_d);
            end
        end
    end

    // Memory strobes and address change together with the cycle clock.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            FETCH_OUT <= RST_FETCH;
            MEM_READ_WRITE_N <= RST_MEM_RW_N;
            UPPER_BYTE_SELECT <= RST_UPPER_SEL;
            LOWER_BYTE_SELECT <= RST_LOWER_SEL;
            MEM_WORD_ADDR_BUS <= '0;
            MEM_DATA_BUS_O <= '0;
            MEM_DATA_BUS_OE <= 1'b0;
        end
        else if (cyc_edge)
        begin
            FETCH_OUT <= kind_d == CPI_FETCH;
            MEM_READ_WRITE_N <= kind_d != CPI_MEM_WR;
            UPPER_BYTE_SELECT <= (kind_d == CPI_FETCH)
                || (is_mem_data(kind_d) && REQ_BYTE_EN[LANE_HIGH]);
            LOWER_BYTE_SELECT <= (kind_d == CPI_FETCH)
                || (is_mem_data(kind_d) && REQ_BYTE_EN[LANE_LOW]);
            if (kind_d == CPI_FETCH)
                MEM_WORD_ADDR_BUS <= REQ_FETCH_ADDR;
            else if (is_mem_data(kind_d))
                MEM_WORD_ADDR_BUS <= REQ_MEM_ADDR;
            MEM_DATA_BUS_O <= REQ_WDATA;
            MEM_DATA_BUS_OE <= kind_d == CPI_MEM_WR;
        end
    end

    // Boot space follows the configuration bit, only at cycle boundaries.
    always_ff @(posedge CLK)
    begin
        if (rst)
            BOOT_SPACE_OUT <= RST_BOOT;
        else if (cyc_edge)
            BOOT_SPACE_OUT <= BOOT_SELECT;
    end

    // Peripheral bus strobes, address and write data.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            IO_CYCLE_N <= RST_IO_CYCLE_N;
            IO_READ_WRITE_N <= RST_IO_RW_N;
            IO_ADDR_BUS <= '0;
            IO_DATA_BUS_O <= '0;
            IO_DATA_BUS_OE <= 1'b0;
            IRQ_ACKNOWLEDGE_OUT <= RST_IRQ_ACK;
        end
        else if (cyc_edge)
        begin
            IO_CYCLE_N <= !((kind_d == CPI_IO_RD)
                || (kind_d == CPI_IO_WR));
            IO_READ_WRITE_N <= kind_d != CPI_IO_WR;
            if ((kind_d == CPI_IO_RD) || (kind_d == CPI_IO_WR))
                IO_ADDR_BUS <= REQ_IO_ADDR;
            IO_DATA_BUS_O <= REQ_WDATA;
            IO_DATA_BUS_OE <= kind_d == CPI_IO_WR;
            IRQ_ACKNOWLEDGE_OUT <= kind_d == CPI_IRQ_ACK;
        end
    end

    // Read data of the closing cycle is handed over one clock after the
    // boundary. The synchroniser output then holds the bus as it stood one
    // clock before the boundary; taking it at the boundary itself would
    // return the bus of the cycle before, as the pins only change there.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            rsp_due_q <= 1'b0;
            rsp_io_q <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_DATA <= '0;
        end
        else
        begin
            rsp_due_q <= cyc_edge && is_read(kind_q);
            rsp_io_q <= kind_q == CPI_IO_RD;
            RSP_VALID <= rsp_due_q;
            if (rsp_due_q)
            begin
                if (rsp_io_q)
                    RSP_DATA <= gd_s;
                else
                    RSP_DATA <= md_s;
            end
        end
    end

    // Level requests are sampled where the cycle clock rises.
    always_ff @(posedge CLK)
    begin
        if (rst)
            IRQ_LEVELS <= '0;
        else if (cyc_edge)
            IRQ_LEVELS <= {tmr_s, lvl_s};
    end

    // Inhibit masks every maskable source, timer inputs included.
    always_ff @(posedge CLK)
    begin
        if (rst)
            IRQ_PENDING <= 1'b0;
        else
            IRQ_PENDING <= (|IRQ_LEVELS) && !inh_s;
    end

    // Timer count pulses on each rising edge, independent of waits.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            tmr_prev_q <= '0;
            TIMER_TICK <= '0;
        end
        else
        begin
            tmr_prev_q <= tmr_s;
            TIMER_TICK <= tmr_s & ~tmr_prev_q;
        end
    end

    // Non-maskable edge latch; a new edge wins over a clear.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            nmi_prev_q <= 1'b0;
            NMI_PENDING <= 1'b0;
        end
        else
        begin
            nmi_prev_q <= nmi_s;
            if (nmi_s && !nmi_prev_q)
                NMI_PENDING <= 1'b1;
            else if (NMI_CLEAR)
                NMI_PENDING <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (rst);

    a_fetch_flag: assert property (
        cyc_edge && (kind_d == CPI_FETCH) |=> FETCH_OUT && UPPER_BYTE_SELECT
            && LOWER_BYTE_SELECT)
        else $error("fetch cycle without fetch indicator");
    a_mem_write_dir: assert property (
        !MEM_READ_WRITE_N |-> MEM_DATA_BUS_OE && !FETCH_OUT)
        else $error("memory write without driving data");
    a_io_write_dir: assert property (
        !IO_READ_WRITE_N |-> !IO_CYCLE_N && IO_DATA_BUS_OE)
        else $error("I/O write outside a driven I/O cycle");
    a_wait_hold_low: assert property (
        wait_s && !CYCLE_CLOCK_OUT |=> !CYCLE_CLOCK_OUT)
        else $error("cycle clock rose during wait");
    a_timing_clk_runs: assert property (
        !FREE_TIMING_CLOCK_OUT |=> FREE_TIMING_CLOCK_OUT
            ##1 !FREE_TIMING_CLOCK_OUT)
        else $error("timing clock stopped");
    a_pclk_in_phase: assert property (
        $rose(CYCLE_CLOCK_OUT) |-> $rose(FREE_TIMING_CLOCK_OUT)
            ##1 !CYCLE_CLOCK_OUT)
        else $error("cycle clock not in phase with timing clock");
    a_addr_at_edge: assert property (
        $changed(MEM_WORD_ADDR_BUS) || $changed(IO_CYCLE_N)
            |-> $rose(CYCLE_CLOCK_OUT))
        else $error("bus output changed off a cycle boundary");
    a_data_then_fetch: assert property (
        $rose(CYCLE_CLOCK_OUT) && $past(data_cycle_q) |-> FETCH_OUT)
        else $error("data access not followed by fetch");
    a_nmi_latch: assert property (
        nmi_s && !nmi_prev_q |=> NMI_PENDING)
        else $error("non-maskable edge lost");
    a_inhibit_block: assert property (
        inh_s |=> !IRQ_PENDING)
        else $error("interrupt pending while inhibited");
    a_ack_alone: assert property (
        IRQ_ACKNOWLEDGE_OUT |-> IO_CYCLE_N && MEM_READ_WRITE_N
            && !FETCH_OUT)
        else $error("acknowledge cycle mixed with a bus access");

    c_mem_write: cover property (
        $fell(MEM_READ_WRITE_N) ##[1:8] $rose(CYCLE_CLOCK_OUT) && FETCH_OUT);
    c_wait_stretch: cover property (
        wait_s && !CYCLE_CLOCK_OUT [*4] ##1 $rose(CYCLE_CLOCK_OUT));
    c_io_read: cover property (
        $fell(IO_CYCLE_N) ##[1:8] RSP_VALID);
    c_nmi_taken: cover property (NMI_PENDING ##1 NMI_CLEAR ##1 !NMI_PENDING);

endmodule : cpi_pins
`default_nettype wire

// file: hw/cpi_pkg.sv
// Shared constants and types of the processor pin interface.
// How it works
// - fetch indicator high during every fetch cycle
// - boot-space output follows configuration bit three
// - memory read/write low on writes, high reads
// - upper byte select high when high lanes used
// - lower byte select high when low lanes used
// - I/O cycle output low during bus operation
// - I/O read/write low on writes, high reads
// - every cycle starts on cycle clock rise
// - cycle clock is input clock halved
// - wait input holds cycle clock low
// - timing clock keeps toggling through waits
// - acknowledge output high during acknowledge cycle
// - reset pin high four clocks resets
// - interrupts one, two sampled at cycle start
// - interrupts three-five also timer edge counts
// - non-maskable input edge sensitive, any cycle
// - inhibit input blocks all maskable requests
// - three-bit I/O address selects peripheral
// - nineteen-bit word address for memory
// - sixteen-bit two-way I/O data bus
// - sixteen-bit two-way memory data bus
// - memory access cycle followed by fetch
package cpi_pkg;

    // Bus widths.
    localparam int MEM_ADDR_W = 19;
    localparam int IO_ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int LEVEL_IRQS = 2;
    localparam int TIMER_IRQS = 3;
    localparam int IRQS = LEVEL_IRQS + TIMER_IRQS;

    // Input clock periods the reset pin must stay high.
    localparam int RESET_HOLD_CLKS = 4;
    localparam logic [2:0] RESET_HOLD_CNT = 3'h4;

    // Pin levels during reset.
    localparam logic RST_FETCH = 1'b1;
    localparam logic RST_BOOT = 1'b1;
    localparam logic RST_MEM_RW_N = 1'b1;
    localparam logic RST_UPPER_SEL = 1'b1;
    localparam logic RST_LOWER_SEL = 1'b1;
    localparam logic RST_IO_CYCLE_N = 1'b1;
    localparam logic RST_IO_RW_N = 1'b1;
    localparam logic RST_IRQ_ACK = 1'b0;

    // Byte lane positions in the byte enable.
    localparam int LANE_LOW = 0;
    localparam int LANE_HIGH = 1;

    // Kind of processor cycle the core asks for.
    typedef enum logic [2:0]
    {
        CPI_IDLE,
        CPI_FETCH,
        CPI_MEM_RD,
        CPI_MEM_WR,
        CPI_IO_RD,
        CPI_IO_WR,
        CPI_IRQ_ACK
    } cpi_kind_t;

endpackage : cpi_pkg

// file: hw/cpi_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ns
`default_nettype none
module cpi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : cpi_sync
`default_nettype wire

// file: hw/cpi_clkgen.sv
// Cycle clock and free timing clock generator, input clock halved.
`timescale 1ns/1ns
`default_nettype none
module cpi_clkgen (
    input wire logic clk,
    input wire logic rst,
    input wire logic hold,
    output logic edge_go,
    output logic pclk_q,
    output logic free_timing_clock_out_q
);

    // A new cycle opens where the timing clock would rise, unless held.
    assign edge_go = !free_timing_clock_out_q && !hold && !rst;

    // Timing clock never stops, so timers keep counting in waits.
    always_ff @(posedge clk)
    begin
        if (rst)
            free_timing_clock_out_q <= 1'b0;
        else
            free_timing_clock_out_q <= !free_timing_clock_out_q;
    end

    // Cycle clock rises in phase with the timing clock or stays low.
    always_ff @(posedge clk)
    begin
        if (rst)
            pclk_q <= 1'b0;
        else
            pclk_q <= edge_go;
    end

endmodule : cpi_clkgen
`default_nettype wire

// file: tb/cpi_far_model.sv
// Far-side model: main memory and one peripheral on the I/O bus.
`timescale 1ns/1ns
`default_nettype none
module cpi_far_model (
    // Clock and pacing control from the bench.
    input wire logic clk,
    input wire logic slow,
    input wire logic cyc_clk,
    // Memory bus.
    input wire logic rw_n,
    input wire logic upper,
    input wire logic lower,
    input wire logic [18:0] maddr,
    input wire logic [15:0] mdo,
    input wire logic mdoe,
    output logic [15:0] mdi,
    // Peripheral I/O bus.
    input wire logic io_n,
    input wire logic io_rw_n,
    input wire logic [2:0] ioaddr,
    input wire logic [15:0] iodo,
    input wire logic iooe,
    output logic [15:0] iodi,
    output logic wait_out
);
    logic [15:0] mem [16];
    logic [15:0] ioreg [8];
    logic [15:0] pat = 16'h5A5A;
    logic [2:0] wcnt = 3'h0;
    logic cyc_prev = 1'b0;

    // Known start contents, so that the bench can predict every read.
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 16'hA500 + 16'(i);
        for (int i = 0; i < 8; i++)
            ioreg[i] = 16'h3C00 + 16'(i);
    end

    // Released lines show a toggling pattern, never the last read value.
    assign mdi = (rw_n && (upper || lower) && !mdoe) ? mem[maddr[3:0]] : pat;
    assign iodi = (!io_n && io_rw_n) ? ioreg[ioaddr] : pat;
    assign wait_out = (wcnt != 3'h0);

    // Memory writes land lane by lane; a slow device waits after each cycle opens.
    always @(posedge clk)
    begin
        pat <= ~pat;
        cyc_prev <= cyc_clk;
        if (mdoe && !rw_n && upper)
            mem[maddr[3:0]][15:8] <= mdo[15:8];
        if (mdoe && !rw_n && lower)
            mem[maddr[3:0]][7:0] <= mdo[7:0];
        if (iooe && !io_n && !io_rw_n)
            ioreg[ioaddr] <= iodo;
        if (slow && cyc_clk && !cyc_prev)
            wcnt <= 3'h6;
        else if (wcnt != 3'h0)
            wcnt <= wcnt - 3'h1;
    end
endmodule : cpi_far_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the processor pin interface.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cpi_pkg::*;
    // Stimulus, changed on the falling clock edge.
    logic clk = 1'b0, rstn = 1'b0, reset_in = 1'b0, nmi = 1'b0;
    logic inhibit = 1'b0, nmiclr = 1'b0, bsel = 1'b0, slow = 1'b0;
    logic [1:0] lvl = 2'h0, rbe = 2'h3;
    logic [2:0] tmr = 3'h0, ria = 3'h0;
    logic [15:0] rwd = 16'h0000;
    logic [18:0] rma = 19'h0_0000, rfa = 19'h0_0000;
    cpi_kind_t kind = CPI_IDLE;
    // Design outputs and far-side lines.
    logic wait_in, pclk, free_timing_clock_out, fetch, boot, mrw_n, usel, lsel, mdoe, io_n;
    logic iorw_n, iooe, ack, taken, rv, irqp, nmip, corerst;
    logic [2:0] ioaddr, tick;
    logic [4:0] irql;
    logic [15:0] mdi, mdo, iodi, iodo, rdata;
    logic [18:0] maddr;
    // Expected answers, memory mirrors and counters.
    logic [15:0] exp_q[$];
    logic [15:0] em [16];
    logic [15:0] eio [8];
    logic [31:0] r = 32'h0001_8406;
    logic [31:0] e;
    int n_fail = 0, n_compared = 0, n_stretch = 0, n_tick = 0, nt = 0;
    logic free_timing_clock_out_prev = 1'b0, pclk_prev = 1'b0, run_prev = 1'b0;
    logic [30:0] bus_prev = 31'h0;
    wire [8:0] pins = {fetch, mrw_n, usel, lsel, io_n, iorw_n, ack, mdoe, iooe};
    wire [31:0] pv = 32'(pins);
    wire [30:0] bus = {pins, maddr, ioaddr};
    wire run = (rstn === 1'b1 && corerst === 1'b0);

    always #5 clk = ~clk;

    cpi_pins DUT (.CLK(clk), .RSTN(rstn), .RESET_IN(reset_in),
        .WAIT_IN(wait_in), .EXT_IRQ_LEVEL_INPUTS(lvl),
        .EXT_IRQ_TIMER_INPUTS(tmr), .NMI_IN(nmi), .IRQ_INHIBIT_IN(inhibit),
        .CYCLE_CLOCK_OUT(pclk), .FREE_TIMING_CLOCK_OUT(free_timing_clock_out),
        .FETCH_OUT(fetch), .BOOT_SPACE_OUT(boot), .MEM_READ_WRITE_N(mrw_n),
        .UPPER_BYTE_SELECT(usel), .LOWER_BYTE_SELECT(lsel),
        .MEM_WORD_ADDR_BUS(maddr), .MEM_DATA_BUS_I(mdi),
        .MEM_DATA_BUS_O(mdo), .MEM_DATA_BUS_OE(mdoe), .IO_CYCLE_N(io_n),
        .IO_READ_WRITE_N(iorw_n), .IO_ADDR_BUS(ioaddr),
        .IO_DATA_BUS_I(iodi), .IO_DATA_BUS_O(iodo), .IO_DATA_BUS_OE(iooe),
        .IRQ_ACKNOWLEDGE_OUT(ack), .REQ_KIND(kind), .REQ_MEM_ADDR(rma),
        .REQ_BYTE_EN(rbe), .REQ_IO_ADDR(ria), .REQ_WDATA(rwd),
        .REQ_FETCH_ADDR(rfa), .BOOT_SELECT(bsel), .REQ_TAKEN(taken),
        .RSP_VALID(rv), .RSP_DATA(rdata), .IRQ_LEVELS(irql),
        .IRQ_PENDING(irqp), .TIMER_TICK(tick), .NMI_PENDING(nmip),
        .NMI_CLEAR(nmiclr), .CORE_RESET_OUT(corerst));

    cpi_far_model far (.clk(clk), .slow(slow), .cyc_clk(pclk),
        .rw_n(mrw_n), .upper(usel), .lower(lsel), .maddr(maddr), .mdo(mdo),
        .mdoe(mdoe), .mdi(mdi), .io_n(io_n), .io_rw_n(iorw_n),
        .ioaddr(ioaddr), .iodo(iodo), .iooe(iooe), .iodi(iodi),
        .wait_out(wait_in));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Strobe pattern of each cycle kind, in the bit order of pins.
    function automatic logic [31:0] strobes(input cpi_kind_t k,
        input logic [1:0] be);
        case (k)
            CPI_FETCH: return 32'h0000_01F8;
            CPI_MEM_RD: return 32'h0000_0098 | (32'(be) << 5);
            CPI_MEM_WR: return 32'h0000_001A | (32'(be) << 5);
            CPI_IO_RD: return 32'h0000_0088;
            CPI_IO_WR: return 32'h0000_0081;
            CPI_IRQ_ACK: return 32'h0000_009C;
            default: return 32'h0000_0098;
        endcase
    endfunction : strobes

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // Bounded wait for one of several events; running out ends the run.
    task automatic await(input int sel);
        for (int n = 0; n < 40; n++)
        begin
            @(negedge clk);
            if (sel == 0 ? taken === 1'b1 : sel == 1 ? pclk === 1'b1 :
                sel == 2 ? corerst === 1'b1 : sel == 3 ? corerst === 1'b0 :
                nmip === 1'b1)
                return;
        end
        chk("bounded wait", 32'h1, 32'h0);
        report_and_stop();
    endtask : await

    task automatic check_reset();
        e = 32'({RST_FETCH, RST_MEM_RW_N, RST_UPPER_SEL, RST_LOWER_SEL,
            RST_IO_CYCLE_N, RST_IO_RW_N, RST_IRQ_ACK, 2'h0, RST_BOOT, 2'h0});
        chk("reset pins", e, 32'({pins, boot, pclk, free_timing_clock_out}));
    endtask : check_reset

    // One request held until taken; pins are checked in the cycle it opens.
    task automatic issue(input cpi_kind_t k);
        logic [18:0] a;
        r = lfsr(r);
        a = (k == CPI_FETCH) ? r[31:13] : r[18:0];
        kind = k;
        rfa = r[31:13];
        rma = a;
        rbe = (r[5:4] == 2'h0) ? 2'h3 : r[5:4];
        ria = r[8:6];
        rwd = r[24:9];
        bsel = r[25];
        await(0);
        chk("pins", strobes(k, rbe), pv);
        chk("boot", 32'(bsel), 32'(boot));
        if (k == CPI_IO_RD || k == CPI_IO_WR)
            chk("io addr", 32'(ria), 32'(ioaddr));
        if (k == CPI_FETCH || k == CPI_MEM_RD || k == CPI_MEM_WR)
            chk("mem addr", 32'(a), 32'(maddr));
        if (k == CPI_MEM_WR)
            chk("mem wdata", 32'(rwd), 32'(mdo));
        if (k == CPI_IO_WR)
            chk("io wdata", 32'(rwd), 32'(iodo));
        case (k)
            CPI_FETCH, CPI_MEM_RD: exp_q.push_back(em[a[3:0]]);
            CPI_IO_RD: exp_q.push_back(eio[ria]);
            CPI_IO_WR: eio[ria] = rwd;
            CPI_MEM_WR:
            begin
                if (rbe[1])
                    em[a[3:0]][15:8] = rwd[15:8];
                if (rbe[0])
                    em[a[3:0]][7:0] = rwd[7:0];
            end
            default: ;
        endcase
        // A data cycle is followed by a fetch that the core did not ask for.
        if (k == CPI_MEM_RD || k == CPI_MEM_WR)
        begin
            await(1);
            e = 32'({2'h2, rfa});
            chk("fetch", e, 32'({fetch, taken, maddr}));
            exp_q.push_back(em[rfa[3:0]]);
        end
    endtask : issue

    // Answer watcher on every falling edge; clock and boundary checks only while out of reset.
    always @(negedge clk)
    begin
        if (rv === 1'b1 && exp_q.size() == 0)
            chk("spare answer", 32'h0, 32'h1);
        else if (rv === 1'b1)
            chk("read data", 32'(exp_q.pop_front()), 32'(rdata));
        if (run && run_prev)
        begin
            n_tick += $countones(tick);
            if (free_timing_clock_out === 1'b1 && pclk === 1'b0)
                n_stretch++;
            chk("timing clock", 32'(!free_timing_clock_out_prev), 32'(free_timing_clock_out));
            if (pclk === 1'b1)
                chk("clock phase", 32'h1, 32'(free_timing_clock_out));
            if (bus !== bus_prev)
                chk("bus step", 32'h1, 32'(pclk & ~pclk_prev));
        end
        free_timing_clock_out_prev = free_timing_clock_out;
        pclk_prev = pclk;
        run_prev = run;
        bus_prev = bus;
    end

    // Main sequence: every cycle kind, waits, interrupts, then pin reset.
    initial
    begin
        for (int i = 0; i < 16; i++)
            em[i] = {12'hA50, 4'(i)};
        for (int i = 0; i < 8; i++)
            eio[i] = {12'h3C0, 4'(i)};
        repeat (4) @(negedge clk);
        check_reset();
        rstn = 1'b1;
        for (int i = 0; i < 30; i++)
            issue(cpi_kind_t'(i < 7 ? 3'(i) : 3'(r[10:8] % 3'h7)));
        issue(CPI_IDLE);
        chk("no stretch", 32'h0, 32'(n_stretch));
        slow = 1'b1;
        issue(CPI_MEM_RD);
        issue(CPI_IO_RD);
        issue(CPI_IDLE);
        slow = 1'b0;
        chk("stretched", 32'h1, 32'(n_stretch != 0));
        for (int i = 0; i < 8; i++)
        begin
            r = lfsr(r);
            nt = nt + $countones(r[4:2] & ~tmr);
            {inhibit, tmr, lvl} = r[5:0];
            repeat (8) @(negedge clk);
            chk("irq levels", 32'({tmr, lvl}), 32'(irql));
            e = 32'((|{tmr, lvl}) && !inhibit);
            chk("irq pending", e, 32'(irqp));
        end
        chk("timer ticks", 32'(nt), 32'(n_tick));
        nmi = 1'b1;
        await(4);
        nmiclr = 1'b1;
        @(negedge clk);
        nmiclr = 1'b0;
        repeat (6) @(negedge clk);
        chk("nmi held level", 32'h0, 32'(nmip));
        nmi = 1'b0;
        reset_in = 1'b1;
        repeat (3) @(negedge clk);
        reset_in = 1'b0;
        repeat (8) @(negedge clk);
        chk("short reset", 32'h0, 32'(corerst));
        reset_in = 1'b1;
        await(2);
        @(negedge clk);
        check_reset();
        reset_in = 1'b0;
        await(3);
        issue(CPI_FETCH);
        issue(CPI_IDLE);
        repeat (4) @(negedge clk);
        chk("answers left", 32'h0, 32'(exp_q.size()));
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
